// [hdl/ext_bus_pkg.sv]
package ext_bus_pkg;

  // ==========================================================
  // Register map (word index, byte address is four times it)
  // ==========================================================
  localparam logic [7:0] CLK_STRETCH_IDX  = 8'h8E;
  localparam logic [7:0] ADDR_CTRL_IDX    = 8'h9D;
  localparam logic [7:0] MEM_ENABLE_IDX   = 8'hC4;
  localparam logic [7:0] STATUS_IDX       = 8'hC5;
  localparam int         IDX_LSB          = 2;
  localparam int         IDX_MSB          = 9;

  // ==========================================================
  // Field layouts and reset values
  // ==========================================================
  localparam int         STRETCH_LSB      = 0;
  localparam int         STRETCH_MSB      = 2;
  localparam int         PAGE_EN_BIT      = 7;
  localparam int         PAGE_SEL_LSB     = 5;
  localparam int         PAGE_SEL_MSB     = 6;
  localparam int         DME_BIT          = 0;
  localparam int         ST_BUSY_BIT      = 0;
  localparam int         ST_VALID_BIT     = 1;
  localparam int         ST_PAGE_LSB      = 8;
  localparam int         ST_PAGE_MSB      = 15;
  localparam logic [7:0] CLK_STRETCH_RST  = 8'h00;
  localparam logic [7:0] ADDR_CTRL_RST    = 8'h00;
  localparam logic [7:0] MEM_ENABLE_RST   = 8'h00;

  // ==========================================================
  // Modes, requests and timing in system clocks
  // ==========================================================
  localparam logic [1:0] PAGE_SEL_ONE     = 2'h0;
  localparam logic [1:0] PAGE_SEL_TWO     = 2'h1;
  localparam logic [1:0] PAGE_SEL_MODE2   = 2'h3;
  localparam logic [5:0] BASIC_EXT_CLKS   = 6'h04;
  localparam logic [5:0] STRETCH_MC_CLKS  = 6'h04;
  localparam logic [5:0] NP_STROBE_BASE   = 6'h02;
  localparam logic [5:0] PM2_FETCH_HALF   = 6'h02;
  localparam logic [5:0] ONE_CLK          = 6'h01;
  localparam logic [5:0] ZERO_CLK         = 6'h00;
  localparam logic [2:0] STRETCH_LONG     = 3'h4;
  localparam logic [15:0] DEFAULT_INT_BYTES = 16'h0400;

  typedef enum logic [1:0] {
    REQ_FETCH = 2'h0,
    REQ_READ  = 2'h1,
    REQ_WRITE = 2'h2
  } req_kind_t;

  typedef enum logic [1:0] {
    BUS_NONPAGE = 2'h0,
    BUS_PAGE1   = 2'h1,
    BUS_PAGE2   = 2'h2
  } bus_mode_t;

  typedef struct packed {
    req_kind_t   kind;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bus_req_t;

  typedef struct packed {
    logic [5:0] latch;
    logic [5:0] setup;
    logic [5:0] strobe;
    logic [5:0] hold;
  } phase_len_t;

endpackage

// [hdl/ext_mem_page_bus_ctrl.sv]
`timescale 1ns/1ps
module ext_mem_page_bus_ctrl
  import ext_bus_pkg::*;
#(
  parameter int INT_DATA_BYTES = 1024
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic             wb_ack_o,
  input  wire bus_req_t    req,
  input  wire logic        req_valid,
  output logic             req_ready,
  output logic             resp_valid,
  output logic [7:0]       resp_data,
  output logic             resp_internal,
  input  wire logic [7:0]  low_port_in,
  output logic      [7:0]  low_port_out,
  output logic             low_port_oe,
  input  wire logic [7:0]  high_port_in,
  output logic      [7:0]  high_port_out,
  output logic             high_port_oe,
  output logic             address_latch_strobe,
  output logic             program_store_strobe_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n
);

  if (INT_DATA_BYTES < 1 || INT_DATA_BYTES > 65536) begin : g_bad_size
    $error("INT_DATA_BYTES must lie between 1 and 65536.");
  end

  localparam logic [16:0] INT_LIMIT = 17'(INT_DATA_BYTES);

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_LATCH  = 5'b00010,
    ST_SETUP  = 5'b00100,
    ST_STROBE = 5'b01000,
    ST_HOLD   = 5'b10000
  } phase_t;

  // ==========================================================
  // Timing functions
  // ==========================================================
  function automatic logic [5:0] stretch_cycles(input logic [2:0] s);
    logic [5:0] c;
    c = {3'h0, s};
    if (s >= STRETCH_LONG) begin
      c = 6'({3'h0, s} + 6'h03);
    end
    return c;
  endfunction

  function automatic phase_len_t data_lens(input logic [2:0] s);
    phase_len_t p;
    logic [5:0] total;
    total    = 6'(BASIC_EXT_CLKS + 6'(stretch_cycles(s) * STRETCH_MC_CLKS));
    p.latch  = ONE_CLK;
    p.hold   = ONE_CLK;
    p.strobe = NP_STROBE_BASE;
    if (s != 3'h0) begin
      p.hold   = 6'(ONE_CLK + ONE_CLK);
      p.strobe = 6'(stretch_cycles(s) * STRETCH_MC_CLKS);
    end
    if (s == 3'h1) begin
      p.strobe = 6'(NP_STROBE_BASE + NP_STROBE_BASE);
    end
    if (s >= STRETCH_LONG) begin
      p.strobe = 6'((stretch_cycles(s) - 6'h03) * STRETCH_MC_CLKS);
      p.latch  = 6'(ONE_CLK + STRETCH_MC_CLKS);
      p.hold   = 6'(ONE_CLK + STRETCH_MC_CLKS);
    end
    p.setup = 6'(total - p.latch - p.strobe - p.hold);
    return p;
  endfunction

  function automatic phase_len_t access_lens(input req_kind_t k, input bus_mode_t m,
                                             input logic [1:0] sel, input logic hit,
                                             input logic [2:0] s);
    phase_len_t p;
    logic [5:0] half;
    half = 6'(ONE_CLK << sel);
    p    = data_lens(s);
    if (k == REQ_FETCH) begin
      case (m)
        BUS_PAGE1: begin
          p = '{latch: (hit ? ZERO_CLK : half), setup: ZERO_CLK, strobe: half, hold: ZERO_CLK};
        end
        BUS_PAGE2: begin
          p = '{latch: (hit ? ZERO_CLK : PM2_FETCH_HALF), setup: ZERO_CLK,
                strobe: PM2_FETCH_HALF, hold: ZERO_CLK};
        end
        default: begin
          p = '{latch: ONE_CLK, setup: ZERO_CLK, strobe: NP_STROBE_BASE, hold: ONE_CLK};
        end
      endcase
    end else if (m == BUS_PAGE1 && hit) begin
      p.setup = 6'(p.setup + p.latch);
      p.latch = ZERO_CLK;
    end
    return p;
  endfunction

  function automatic phase_t first_phase(input phase_len_t p, input phase_t from);
    phase_t n;
    n = ST_IDLE;
    if (from == ST_IDLE && p.latch != ZERO_CLK) begin
      n = ST_LATCH;
    end else if ((from == ST_IDLE || from == ST_LATCH) && p.setup != ZERO_CLK) begin
      n = ST_SETUP;
    end else if (from != ST_STROBE && from != ST_HOLD) begin
      n = ST_STROBE;
    end else if (from == ST_STROBE && p.hold != ZERO_CLK) begin
      n = ST_HOLD;
    end
    return n;
  endfunction

  function automatic logic [5:0] phase_len(input phase_len_t p, input phase_t ph);
    logic [5:0] l;
    case (ph)
      ST_LATCH:  l = p.latch;
      ST_SETUP:  l = p.setup;
      ST_STROBE: l = p.strobe;
      ST_HOLD:   l = p.hold;
      default:   l = ZERO_CLK;
    endcase
    return l;
  endfunction

  // ==========================================================
  // Register file on the Wishbone bus
  // ==========================================================
  logic [7:0]  clk_stretch_q;
  logic [7:0]  addr_ctrl_q;
  logic [7:0]  mem_enable_q;
  logic [7:0]  page_q;
  logic        page_valid_q;
  logic        force_miss_q;
  phase_t      state_q;
  phase_t      state_d;
  logic [5:0]  cnt_q;
  logic [5:0]  cnt_d;
  phase_len_t  lens_q;
  phase_len_t  lens_new;
  bus_req_t    cur_q;
  bus_mode_t   mode_q;
  bus_mode_t   mode_now;
  logic [7:0]  idx;
  logic        wb_hit;
  logic        wr_en;
  logic        mode_write;
  logic        accept;
  logic        internal;
  logic        is_hit;

  assign idx        = wb_adr_i[IDX_MSB:IDX_LSB];
  assign wb_hit     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en      = ce && wb_hit && wb_we_i && wb_sel_i[0];
  assign mode_write = wr_en && idx == ADDR_CTRL_IDX;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce) begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= '0;
      if (wb_hit && !wb_we_i) begin
        case (idx)
          CLK_STRETCH_IDX: wb_dat_o <= {24'h0, clk_stretch_q};
          ADDR_CTRL_IDX:   wb_dat_o <= {24'h0, addr_ctrl_q};
          MEM_ENABLE_IDX:  wb_dat_o <= {24'h0, mem_enable_q};
          STATUS_IDX: begin
            wb_dat_o[ST_PAGE_MSB:ST_PAGE_LSB] <= page_q;
            wb_dat_o[ST_VALID_BIT]            <= page_valid_q;
            wb_dat_o[ST_BUSY_BIT]             <= state_q != ST_IDLE;
          end
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      clk_stretch_q <= CLK_STRETCH_RST;
      addr_ctrl_q   <= ADDR_CTRL_RST;
      mem_enable_q  <= MEM_ENABLE_RST;
    end else if (wr_en) begin
      case (idx)
        CLK_STRETCH_IDX: clk_stretch_q <= wb_dat_i[7:0];
        ADDR_CTRL_IDX:   addr_ctrl_q   <= wb_dat_i[7:0];
        MEM_ENABLE_IDX:  mem_enable_q  <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Request decode and page compare
  // ==========================================================
  always_comb begin
    mode_now = BUS_NONPAGE;
    if (addr_ctrl_q[PAGE_EN_BIT]) begin
      mode_now = (addr_ctrl_q[PAGE_SEL_MSB:PAGE_SEL_LSB] == PAGE_SEL_MODE2) ? BUS_PAGE2 : BUS_PAGE1;
    end
  end

  assign accept   = ce && req_valid && req_ready;
  assign internal = req.kind != REQ_FETCH && mem_enable_q[DME_BIT]
                    && {1'b0, req.addr} < INT_LIMIT;
  assign is_hit   = page_valid_q && page_q == req.addr[15:8] && !force_miss_q
                    && !(req.kind != REQ_FETCH
                         && addr_ctrl_q[PAGE_SEL_MSB:PAGE_SEL_LSB] == PAGE_SEL_ONE);
  assign lens_new = access_lens(req.kind, mode_now, addr_ctrl_q[PAGE_SEL_MSB:PAGE_SEL_LSB],
                                is_hit, clk_stretch_q[STRETCH_MSB:STRETCH_LSB]);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      page_q       <= 8'h00;
      page_valid_q <= 1'b0;
      force_miss_q <= 1'b0;
    end else if (ce) begin
      if (mode_write) begin
        page_valid_q <= 1'b0;
      end else if (accept && !internal && mode_now != BUS_NONPAGE) begin
        page_q       <= req.addr[15:8];
        page_valid_q <= 1'b1;
      end
      if (accept && !internal) begin
        force_miss_q <= req.kind != REQ_FETCH
                        && addr_ctrl_q[PAGE_SEL_MSB:PAGE_SEL_LSB] == PAGE_SEL_ONE;
      end
    end
  end

  // ==========================================================
  // Cycle sequencer
  // ==========================================================
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (state_q == ST_IDLE) begin
      if (accept && !internal) begin
        state_d = first_phase(lens_new, ST_IDLE);
        cnt_d   = phase_len(lens_new, state_d);
      end
    end else if (cnt_q == ONE_CLK) begin
      state_d = first_phase(lens_q, state_q);
      cnt_d   = phase_len(lens_q, state_d);
    end else begin
      cnt_d = 6'(cnt_q - ONE_CLK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cnt_q   <= ZERO_CLK;
      lens_q  <= '0;
      cur_q   <= '0;
      mode_q  <= BUS_NONPAGE;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (accept) begin
        lens_q <= lens_new;
        cur_q  <= req;
        mode_q <= mode_now;
      end
    end
  end

  // The ready flag falls with the accepting edge, so a request is never taken twice.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_ready     <= 1'b0;
      resp_valid    <= 1'b0;
      resp_data     <= 8'h00;
      resp_internal <= 1'b0;
    end else if (ce) begin
      req_ready     <= state_d == ST_IDLE && !accept;
      resp_valid    <= 1'b0;
      resp_internal <= 1'b0;
      if (accept && internal) begin
        resp_valid    <= 1'b1;
        resp_internal <= 1'b1;
        resp_data     <= 8'h00;
      end else if (state_q != ST_IDLE && state_d == ST_IDLE) begin
        resp_valid <= 1'b1;
      end
      if (state_q == ST_STROBE && cnt_q == ONE_CLK && cur_q.kind != REQ_WRITE) begin
        resp_data <= (mode_q == BUS_PAGE2) ? high_port_in : low_port_in;
      end
    end
  end

  // ==========================================================
  // Pin drivers, registered from the next phase
  // ==========================================================
  logic [2:0] roles;
  bus_req_t   nreq;
  bus_mode_t  nmode;
  logic       nwr;
  assign nreq  = (state_q == ST_IDLE) ? req : cur_q;
  assign nmode = (state_q == ST_IDLE) ? mode_now : mode_q;
  assign nwr   = nreq.kind == REQ_WRITE;
  assign roles = {state_d == ST_LATCH, state_d == ST_STROBE, state_d == ST_IDLE};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      low_port_out           <= 8'h00;
      low_port_oe            <= 1'b0;
      high_port_out          <= 8'h00;
      high_port_oe           <= 1'b0;
      address_latch_strobe   <= 1'b0;
      program_store_strobe_n <= 1'b1;
      read_strobe_n          <= 1'b1;
      write_strobe_n         <= 1'b1;
    end else if (ce) begin
      address_latch_strobe   <= roles[2];
      program_store_strobe_n <= !(roles[1] && nreq.kind == REQ_FETCH);
      read_strobe_n          <= !(roles[1] && nreq.kind == REQ_READ);
      write_strobe_n         <= !(roles[1] && nwr);
      high_port_oe           <= !roles[0];
      low_port_oe            <= 1'b0;
      high_port_out          <= nreq.addr[15:8];
      low_port_out           <= nreq.addr[7:0];
      case (nmode)
        BUS_PAGE1: begin
          if (!roles[2]) begin
            high_port_out <= nreq.addr[7:0];
            low_port_out  <= nreq.wdata;
            low_port_oe   <= nwr && !roles[0];
          end
        end
        BUS_PAGE2: begin
          low_port_oe <= !roles[0];
          if (!roles[2]) begin
            high_port_out <= nreq.wdata;
            high_port_oe  <= nwr && !roles[0];
          end
        end
        default: begin
          low_port_oe <= roles[2];
          if (!roles[2] && nwr && !roles[0]) begin
            low_port_out <= nreq.wdata;
            low_port_oe  <= 1'b1;
          end
        end
      endcase
      if (roles[0]) begin
        high_port_oe <= 1'b0;
      end
    end
  end

endmodule

// [verification/ext_bus_props.sv]
`timescale 1ns/1ps
module ext_bus_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic resp_internal,
  input wire logic low_port_oe,
  input wire logic high_port_oe,
  input wire logic address_latch_strobe,
  input wire logic program_store_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n
);
  // ==========================================================
  // Port timing relations
  // ==========================================================
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_ack_answer: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_ack_single: assert property (ce && wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ready_drop: assert property (ce && req_valid && req_ready |=> !req_ready) else $error("ready held");
  chk_one_strobe: assert property ($onehot0({!program_store_strobe_n, !read_strobe_n, !write_strobe_n}))
    else $error("two strobes");
  chk_latch_quiet: assert property (address_latch_strobe |-> program_store_strobe_n && read_strobe_n
    && write_strobe_n) else $error("strobe in latch");
  chk_read_float: assert property (!read_strobe_n || !program_store_strobe_n |-> !(low_port_oe && high_port_oe))
    else $error("data port driven");
  chk_write_drive: assert property (!write_strobe_n |-> low_port_oe && high_port_oe)
    else $error("write data floats");
  chk_int_quiet: assert property (resp_internal |-> resp_valid && read_strobe_n && !address_latch_strobe)
    else $error("internal on bus");
  chk_strobe_width: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*2])
    else $error("read strobe short");
  // Reset itself is the antecedent here, so the default disable is overridden.
  chk_reset_idle: assert property (disable iff (1'b0) reset && ce |=> !req_ready && read_strobe_n
    && write_strobe_n && !address_latch_strobe && !low_port_oe) else $error("bus not idle");
  cov_internal: cover property (resp_internal);
  cov_latch: cover property (address_latch_strobe);
  cov_write: cover property (!write_strobe_n);
endmodule
bind ext_mem_page_bus_ctrl ext_bus_props chk (
  .core_clk, .reset, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .req_valid, .req_ready, .resp_valid,
  .resp_internal, .low_port_oe, .high_port_oe, .address_latch_strobe, .program_store_strobe_n,
  .read_strobe_n, .write_strobe_n
);

// [verification/ext_mem_model.sv]
`timescale 1ns/1ps
module ext_mem_model
  import ext_bus_pkg::*;
(
  input  wire logic       core_clk,
  input  wire bus_mode_t  mode,
  input  wire logic [7:0] low_port_out,
  input  wire logic       low_port_oe,
  input  wire logic [7:0] high_port_out,
  input  wire logic       high_port_oe,
  input  wire logic       address_latch_strobe,
  input  wire logic       program_store_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  output logic      [7:0] low_port_in,
  output logic      [7:0] high_port_in
);
  // ==========================================================
  // Address latch, storage and read drive
  // ==========================================================
  logic [7:0]  mem [0:65535];
  bit          wrote [0:65535];
  logic [7:0]  lat_lo_q = 8'h00, lat_hi_q = 8'h00, lo_q = 8'h00, hi_q = 8'h00, rd_d;
  logic [15:0] addr_d;
  logic        rd_on;
  always @(posedge core_clk) begin
    if (address_latch_strobe) begin
      lat_lo_q <= low_port_out;
      lat_hi_q <= high_port_out;
    end
    if (!write_strobe_n) begin
      mem[addr_d] <= (mode == BUS_PAGE2) ? high_port_out : low_port_out;
      wrote[addr_d] <= 1'b1;
    end
    lo_q <= low_port_in;
    hi_q <= high_port_in;
  end
  always @* begin
    case (mode)
      BUS_PAGE1: addr_d = {lat_hi_q, high_port_out};
      BUS_PAGE2: addr_d = {lat_hi_q, low_port_out};
      default:   addr_d = {high_port_out, lat_lo_q};
    endcase
    rd_on = !read_strobe_n || !program_store_strobe_n;
    rd_d  = wrote[addr_d] ? mem[addr_d] : addr_d[7:0] ^ addr_d[15:8] ^ 8'h5A;
  end
  // A released line shows the inverse of its last level, so a late sample cannot match by luck.
  assign low_port_in  = low_port_oe ? low_port_out : (rd_on && mode != BUS_PAGE2) ? rd_d : ~lo_q;
  assign high_port_in = high_port_oe ? high_port_out : (rd_on && mode == BUS_PAGE2) ? rd_d : ~hi_q;
endmodule

// [verification/ext_mem_page_bus_ctrl_tb.sv]
`timescale 1ns/1ps
module ext_mem_page_bus_ctrl_tb
  import ext_bus_pkg::*;
();
  logic        core_clk = 1'b0, reset = 1'b1, ce = 1'b1, wb_we_i = 1'b0, wb_stb_i = 1'b0, wb_cyc_i = 1'b0;
  logic        req_valid = 1'b0, wb_ack_o, req_ready, resp_valid, resp_internal, low_port_oe, high_port_oe;
  logic        address_latch_strobe, program_store_strobe_n, read_strobe_n, write_strobe_n, got_int;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [7:0]  resp_data, low_port_in, low_port_out, high_port_in, high_port_out, got;
  bus_req_t    req = '0;
  bus_mode_t   mode = BUS_NONPAGE;
  int          fails = 0, comparisons = 0, cycles = 0, n, latch_cnt, prog_cnt, stb_cnt;
  ext_mem_page_bus_ctrl #(.INT_DATA_BYTES(1024)) uut (
    .core_clk, .reset, .ce, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i,
    .wb_ack_o, .req, .req_valid, .req_ready, .resp_valid, .resp_data, .resp_internal, .low_port_in,
    .low_port_out, .low_port_oe, .high_port_in, .high_port_out, .high_port_oe, .address_latch_strobe,
    .program_store_strobe_n, .read_strobe_n, .write_strobe_n
  );
  ext_mem_model far_mem (
    .core_clk, .mode, .low_port_out, .low_port_oe, .high_port_out, .high_port_oe, .address_latch_strobe,
    .program_store_strobe_n, .read_strobe_n, .write_strobe_n, .low_port_in, .high_port_in
  );
  // ==========================================================
  // Clock, watchdog and reporting
  // ==========================================================
  initial forever #4 core_clk = ~core_clk;
  // The ceiling is several times the longest run, so only a hang reaches it.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] fill(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  // ==========================================================
  // Bus cycles
  // ==========================================================
  task automatic wb(input string nm, input logic we, input logic [7:0] idx, input logic [15:0] d);
    wb_adr_i <= {22'h0, idx, 2'h0};
    wb_dat_i <= {16'h0, d};
    wb_we_i  <= we;
    {wb_cyc_i, wb_stb_i} <= 2'h3;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    if (!we) check(nm, wb_dat_o, {16'h0, d});
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge core_clk);
  endtask
  task automatic acc(input req_kind_t k, input logic [15:0] a, input logic [7:0] w);
    req       <= '{kind: k, addr: a, wdata: w};
    req_valid <= 1'b1;
    do @(posedge core_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    {n, latch_cnt, prog_cnt, stb_cnt} = '0;
    do begin
      @(posedge core_clk);
      n++;
      latch_cnt += (address_latch_strobe === 1'b1);
      prog_cnt  += (program_store_strobe_n === 1'b0);
      stb_cnt   += (read_strobe_n === 1'b0 || write_strobe_n === 1'b0);
    end while (resp_valid !== 1'b1);
    got     = resp_data;
    got_int = resp_internal;
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_regs();
    wb("stretch rst", 1'b0, CLK_STRETCH_IDX, CLK_STRETCH_RST);
    wb("mode rst", 1'b0, ADDR_CTRL_IDX, 8'h00);
    wb("enable rst", 1'b0, MEM_ENABLE_IDX, 8'h00);
    wb("", 1'b1, 8'h10, 8'h5A);
    wb("unmapped", 1'b0, 8'h10, 8'h00);
    wb_sel_i <= 4'hE;
    wb("", 1'b1, CLK_STRETCH_IDX, 8'h07);
    wb_sel_i <= 4'hF;
    wb("masked", 1'b0, CLK_STRETCH_IDX, 8'h00);
  endtask
  task automatic t_nonpage();
    int tot;
    for (int i = 0; i < 8; i++) begin
      tot = (i == 0) ? 4 : (i < 4) ? 4 * i + 4 : 4 * i + 16;
      wb("", 1'b1, CLK_STRETCH_IDX, i[7:0]);
      wb("stretch", 1'b0, CLK_STRETCH_IDX, i[7:0]);
      acc(REQ_WRITE, 16'h1200 + i[15:0], 8'hC0 + i[7:0]);
      check("np strobe", stb_cnt, (i == 0) ? 2 : 4 * i);
      check("np wr len", n, tot + 1);
      check("np latch", latch_cnt, (i < 4) ? 1 : 5);
      acc(REQ_READ, 16'h1200 + i[15:0], 8'h00);
      check("np data", got, 8'hC0 + i[7:0]);
      check("np rd len", n, tot + 1);
    end
    wb("", 1'b1, CLK_STRETCH_IDX, 8'h00);
  endtask
  task automatic t_internal();
    wb("", 1'b1, MEM_ENABLE_IDX, 8'h01);
    acc(REQ_READ, 16'h03FF, 8'h00);
    check("int flag", got_int, 1'b1);
    check("int len", n, 1);
    acc(REQ_READ, 16'h0400, 8'h00);
    check("ext flag", got_int, 1'b0);
    check("ext data", got, fill(16'h0400));
    acc(REQ_WRITE, 16'hFFFF, 8'h3C);
    acc(REQ_READ, 16'hFFFF, 8'h00);
    check("top data", got, 8'h3C);
    wb("", 1'b1, MEM_ENABLE_IDX, 8'h00);
  endtask
  task automatic t_page1();
    int h;
    for (int s = 0; s < 3; s++) begin
      h = 1 << s;
      mode <= BUS_PAGE1;
      wb("", 1'b1, ADDR_CTRL_IDX, {1'b1, s[1:0], 5'h00});
      acc(REQ_FETCH, 16'h3400, 8'h00);
      check("p1 miss", n, 2 * h + 1);
      check("p1 fetch", got, fill(16'h3400));
      acc(REQ_FETCH, 16'h3401, 8'h00);
      check("p1 hit", n, h + 1);
      check("p1 hit latch", latch_cnt, 0);
      check("p1 strobe", prog_cnt, h);
      acc(REQ_WRITE, 16'h3402, 8'hA0 + s[7:0]);
      check("p1 move len", n, 5);
      check("p1 move miss", latch_cnt > 0, s == 0);
      acc(REQ_READ, 16'h3402, 8'h00);
      check("p1 move data", got, 8'hA0 + s[7:0]);
      acc(REQ_FETCH, 16'h3403, 8'h00);
      check("p1 after move", n, (s == 0) ? 3 : h + 1);
    end
    wb("status", 1'b0, STATUS_IDX, 16'h3402);
  endtask
  task automatic t_page2();
    mode <= BUS_PAGE2;
    wb("", 1'b1, ADDR_CTRL_IDX, 8'hE0);
    acc(REQ_FETCH, 16'h5600, 8'h00);
    check("p2 miss", n, 5);
    check("p2 fetch", got, fill(16'h5600));
    acc(REQ_FETCH, 16'h5601, 8'h00);
    check("p2 hit", n, 3);
    acc(REQ_WRITE, 16'h5610, 8'h69);
    acc(REQ_READ, 16'h5610, 8'h00);
    check("p2 data", got, 8'h69);
    check("p2 move len", n, 5);
  endtask
  task automatic t_reset_mode();
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    mode  <= BUS_NONPAGE;
    @(posedge core_clk);
    wb("mode cleared", 1'b0, ADDR_CTRL_IDX, 8'h00);
    acc(REQ_FETCH, 16'h5601, 8'h00);
    check("np fetch len", n, 5);
    check("np fetch", got, fill(16'h5601));
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_nonpage();
    t_internal();
    t_page1();
    t_page2();
    t_reset_mode();
    close_out();
  end
endmodule
